/* src/ifr_pkg.sv */
package ifr_pkg;

  localparam int          IFR_DW        = 16;
  localparam int          IFR_AW        = 6;
  localparam int          IFR_NUM_FLG   = 5;
  localparam int          IFR_NUM_EXT   = 3;

  // Byte offsets of the register words
  localparam logic [5:0]  OFF_CTL_TWO   = 6'h00;
  localparam logic [5:0]  OFF_FLAGS_0   = 6'h04;
  localparam logic [5:0]  OFF_FLAGS_1   = 6'h08;
  localparam logic [5:0]  OFF_FLAGS_2   = 6'h0c;
  localparam logic [5:0]  OFF_FLAGS_3   = 6'h10;
  localparam logic [5:0]  OFF_FLAGS_4   = 6'h14;
  localparam logic [5:0]  OFF_EV_STAT   = 6'h18;
  localparam logic [5:0]  OFF_EV_MASK   = 6'h1c;

  // Control register field positions
  localparam int          CTL_ALT_BIT   = 15;
  localparam int          CTL_IDIS_BIT  = 14;
  localparam int          CTL_EP0_BIT   = 0;

  // Implemented bits of each flag register, full family
  localparam logic [15:0] FLG0_IMPL     = 16'hb9cd;
  localparam logic [15:0] FLG1_IMPL     = 16'hea1f;
  localparam logic [15:0] FLG2_IMPL     = 16'h0020;
  localparam logic [15:0] FLG3_IMPL     = 16'h0006;
  localparam logic [15:0] FLG4_IMPL     = 16'h0106;

  // Bits absent on reduced family members
  localparam logic [15:0] FLG0_REDUCED  = 16'h0000;
  localparam logic [15:0] FLG1_REDUCED  = 16'hca00;
  localparam logic [15:0] FLG2_REDUCED  = 16'h0000;
  localparam logic [15:0] FLG3_REDUCED  = 16'h0006;
  localparam logic [15:0] FLG4_REDUCED  = 16'h0004;

  // Control register read and write masks
  localparam logic [15:0] CTL_RD_MASK   = 16'hc007;
  localparam logic [15:0] CTL_WR_MASK   = 16'h8007;

  // Where the external request flags sit
  localparam int          EXT0_REG      = 0;
  localparam int          EXT0_BIT      = 0;
  localparam int          EXT1_REG      = 1;
  localparam int          EXT1_BIT      = 4;
  localparam int          EXT2_REG      = 1;
  localparam int          EXT2_BIT      = 13;

  localparam logic [15:0] REG_RST_VAL   = 16'h0000;
  localparam logic [4:0]  EV_RST_VAL    = 5'h00;

  typedef enum logic [1:0] {
    IFR_ST_IDLE = 2'b01,
    IFR_ST_ACK  = 2'b10
  } ifr_bus_st_t;

  typedef struct packed {
    logic       alt;
    logic       dis_act;
    logic [2:0] pol;
  } ifr_ctl_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [5:0]  adr;
    logic [31:0] dat;
  } ifr_wb_req_t;

endpackage : ifr_pkg

/* src/ifr_regs.sv */
`timescale 1ns/1ps

// Summary of operation
// - Control bit 15 selects alternate vector table
// - Control bit 14 mirrors disable-instruction status, read-only
// - Control bits 2:0: 1 falling, 0 rising
// - Flag register zero holds ten source flags
// - Flag register one holds ten source flags
// - Flag register two: only timer3 gate bit
// - Flag register three: port2 collision and event
// - Flag register four: voltage detect, serial errors
// - Flags show request; software may read/write
// - Unimplemented bits always read zero
// - All implemented bits reset to zero
// - Reduced members drop second-port and timer4 flags
// - Sources set flags; software clears by writing
module ifr_regs
  import ifr_pkg::*;
#(
  parameter bit FULL_FAMILY = 1'b1
)(
  input  wire logic                         clk,                 // System clock
  input  wire logic                         nrst,                // Async reset, active low
  input  wire logic                         wb_cyc_i,            // Bus cycle
  input  wire logic                         wb_stb_i,            // Bus strobe
  input  wire logic                         wb_we_i,             // Write enable
  input  wire logic [IFR_AW-1:0]            wb_adr_i,            // Byte address
  input  wire logic [3:0]                   wb_sel_i,            // Byte lane selects
  input  wire logic [31:0]                  wb_dat_i,            // Write data
  output logic      [31:0]                  wb_dat_o,            // Read data
  output logic                              wb_ack_o,            // Bus acknowledge
  input  wire logic [IFR_NUM_FLG-1:0][15:0] flag_set,            // Per-source set pulses
  input  wire logic                         irq_disable_active,  // Disable instruction in effect
  input  wire logic [IFR_NUM_EXT-1:0]       ext_pin,             // External request pins
  output logic                              alt_vector_select,   // Alternate table in use
  output logic      [IFR_NUM_EXT-1:0]       ext_edge_polarity,   // 1 falling, 0 rising
  output logic      [IFR_NUM_FLG-1:0][15:0] flags,               // Request flag registers
  output logic                              irq                  // Summary interrupt
);

  function automatic logic [15:0] impl_mask(input int idx);
    logic [15:0] base;
    logic [15:0] red;
    base = 16'h0000;
    red  = 16'h0000;
    case (idx)
      0: begin base = FLG0_IMPL; red = FLG0_REDUCED; end
      1: begin base = FLG1_IMPL; red = FLG1_REDUCED; end
      2: begin base = FLG2_IMPL; red = FLG2_REDUCED; end
      3: begin base = FLG3_IMPL; red = FLG3_REDUCED; end
      4: begin base = FLG4_IMPL; red = FLG4_REDUCED; end
      default: begin base = 16'h0000; red = 16'h0000; end
    endcase
    return FULL_FAMILY ? base : (base & ~red);
  endfunction : impl_mask

  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [15:0] wdat,
                                             input logic [3:0]  sel);
    logic [15:0] res;
    res = old;
    if (sel[0])
    begin
      res[7:0] = wdat[7:0];
    end
    if (sel[1])
    begin
      res[15:8] = wdat[15:8];
    end
    return res;
  endfunction : lane_merge

  function automatic logic [5:0] flag_off(input int idx);
    return OFF_FLAGS_0 + 6'(idx * 4);
  endfunction : flag_off

  ifr_wb_req_t                    req;
  ifr_bus_st_t                    st_r;
  ifr_bus_st_t                    st_nxt;
  ifr_ctl_t                       ctl_r;
  logic [IFR_NUM_FLG-1:0][15:0]   flag_r;
  logic [IFR_NUM_FLG-1:0][15:0]   flag_nxt;
  logic [IFR_NUM_FLG-1:0][15:0]   hw_set;
  logic [IFR_NUM_FLG-1:0]         ev_stat_r;
  logic [IFR_NUM_FLG-1:0]         ev_mask_r;
  logic [IFR_NUM_FLG-1:0]         ev_stat_nxt;
  logic [IFR_NUM_EXT-1:0]         pin_s1_r;
  logic [IFR_NUM_EXT-1:0]         pin_s2_r;
  logic [IFR_NUM_EXT-1:0]         pin_prev_r;
  logic [IFR_NUM_EXT-1:0]         ext_edge;
  logic                           wr_en;
  logic [15:0]                    wdat;
  logic [31:0]                    rd_nxt;
  logic                           irq_r;
  logic [5:0]                     adr_w;
  logic [15:0]                    ctl_wr;

  assign req  = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
  assign wdat = req.dat[15:0];
  assign adr_w = req.adr & 6'h3c;
  // Control word as the write would leave it; the status bit is never taken from it
  assign ctl_wr = lane_merge({ctl_r.alt, 12'h000, ctl_r.pol}, wdat, req.sel);
  // Writes land on the edge at which the master samples ack
  assign wr_en = req.cyc && req.stb && req.we && (st_r == IFR_ST_ACK);

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      IFR_ST_IDLE: st_nxt = (req.cyc && req.stb) ? IFR_ST_ACK : IFR_ST_IDLE;
      IFR_ST_ACK:  st_nxt = IFR_ST_IDLE;
      default:     st_nxt = IFR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= IFR_ST_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r[1];

  // Read data is captured when the request is first seen
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (req.adr & 6'h3c)
      OFF_CTL_TWO: rd_nxt[15:0] = {ctl_r.alt, ctl_r.dis_act, 11'h000, ctl_r.pol} & CTL_RD_MASK;
      OFF_FLAGS_0: rd_nxt[15:0] = flag_r[0] & impl_mask(0);
      OFF_FLAGS_1: rd_nxt[15:0] = flag_r[1] & impl_mask(1);
      OFF_FLAGS_2: rd_nxt[15:0] = flag_r[2] & impl_mask(2);
      OFF_FLAGS_3: rd_nxt[15:0] = flag_r[3] & impl_mask(3);
      OFF_FLAGS_4: rd_nxt[15:0] = flag_r[4] & impl_mask(4);
      OFF_EV_STAT: rd_nxt[4:0]  = ev_stat_r;
      OFF_EV_MASK: rd_nxt[4:0]  = ev_mask_r;
      default:     rd_nxt       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (req.cyc && req.stb && (st_r == IFR_ST_IDLE))
    begin
      wb_dat_o <= rd_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_r <= '0;
    end
    else
    begin
      ctl_r.dis_act <= irq_disable_active;
      if (wr_en && (adr_w == OFF_CTL_TWO))
      begin
        ctl_r.alt <= ctl_wr[CTL_ALT_BIT];
        ctl_r.pol <= ctl_wr[CTL_EP0_BIT +: 3];
      end
    end
  end

  assign alt_vector_select = ctl_r.alt;
  assign ext_edge_polarity = ctl_r.pol;

  // Pin synchroniser; the last stage keeps the previous level
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_s1_r   <= '0;
      pin_s2_r   <= '0;
      pin_prev_r <= '0;
    end
    else
    begin
      pin_s1_r   <= ext_pin;
      pin_s2_r   <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end

  always_comb
  begin
    for (int i = 0; i < IFR_NUM_EXT; i++)
    begin
      ext_edge[i] = ctl_r.pol[i] ? (pin_prev_r[i] && !pin_s2_r[i]) : (!pin_prev_r[i] && pin_s2_r[i]);
    end
  end

  always_comb
  begin
    hw_set = flag_set;
    hw_set[EXT0_REG][EXT0_BIT] = flag_set[EXT0_REG][EXT0_BIT] | ext_edge[0];
    hw_set[EXT1_REG][EXT1_BIT] = flag_set[EXT1_REG][EXT1_BIT] | ext_edge[1];
    hw_set[EXT2_REG][EXT2_BIT] = flag_set[EXT2_REG][EXT2_BIT] | ext_edge[2];
    for (int k = 0; k < IFR_NUM_FLG; k++)
    begin
      hw_set[k] = hw_set[k] & impl_mask(k);
    end
  end

  always_comb
  begin
    flag_nxt = flag_r;
    for (int k = 0; k < IFR_NUM_FLG; k++)
    begin
      if (wr_en && ((req.adr & 6'h3c) == flag_off(k)))
      begin
        flag_nxt[k] = lane_merge(flag_r[k], wdat, req.sel) & impl_mask(k);
      end
      flag_nxt[k] = flag_nxt[k] | hw_set[k];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      flag_r <= {IFR_NUM_FLG{REG_RST_VAL}};
    end
    else
    begin
      flag_r <= flag_nxt;
    end
  end

  assign flags = flag_r;

  // Event status: one sticky bit per flag register, write one to clear
  always_comb
  begin
    ev_stat_nxt = ev_stat_r;
    if (wr_en && ((req.adr & 6'h3c) == OFF_EV_STAT) && req.sel[0])
    begin
      ev_stat_nxt = ev_stat_r & ~wdat[4:0];
    end
    for (int k = 0; k < IFR_NUM_FLG; k++)
    begin
      ev_stat_nxt[k] = ev_stat_nxt[k] | (|hw_set[k]);
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ev_stat_r <= EV_RST_VAL;
    end
    else
    begin
      ev_stat_r <= ev_stat_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ev_mask_r <= EV_RST_VAL;
    end
    else if (wr_en && ((req.adr & 6'h3c) == OFF_EV_MASK) && req.sel[0])
    begin
      ev_mask_r <= wdat[4:0];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= |(ev_stat_r & ev_mask_r);
    end
  end

  assign irq = irq_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_ALT_WRITE: assert property (
    (wr_en && ((req.adr & 6'h3c) == OFF_CTL_TWO) && req.sel[1]) |=> (alt_vector_select == $past(wdat[15])))
    else $error("alternate table bit did not take written value");

  AST_IDIS_READ: assert property (
    (req.cyc && req.stb && !req.we && (st_r == IFR_ST_IDLE) && (adr_w == OFF_CTL_TWO))
      |=> (wb_ack_o && (wb_dat_o[CTL_IDIS_BIT] == $past(irq_disable_active, 2))))
    else $error("disable status read back wrong");

  AST_EXT0_EDGE: assert property (
    (pin_s2_r[0] != pin_prev_r[0]) && (pin_s2_r[0] == !ctl_r.pol[0]) |=> flag_r[EXT0_REG][EXT0_BIT])
    else $error("external edge of selected polarity did not set flag");

  AST_FLAG_SET: assert property (
    flag_set[0][13] |=> (flag_r[0][13] && flags[0][13]))
    else $error("source set pulse did not raise its flag");

  AST_FLAG1_SET: assert property (
    flag_set[1][3] |=> flag_r[1][3])
    else $error("flag register one source did not set");

  AST_FLAG2_ONLY: assert property (
    (flag_r[2] & ~FLG2_IMPL) == 16'h0000)
    else $error("unimplemented flag register two bit set");

  AST_FLAG3_ONLY: assert property (
    (flag_r[3] & ~FLG3_IMPL) == 16'h0000)
    else $error("unimplemented flag register three bit set");

  AST_FLAG4_ONLY: assert property (
    (flag_r[4] & ~FLG4_IMPL) == 16'h0000)
    else $error("unimplemented flag register four bit set");

  AST_RD_ZERO: assert property (
    wb_ack_o && ($past(adr_w) == OFF_CTL_TWO) |-> (wb_dat_o[13:3] == 11'h000 && wb_dat_o[31:16] == 16'h0000))
    else $error("unimplemented control bits read nonzero");

  AST_RESET_ZERO: assert property (@(posedge clk) disable iff (1'b0)
    !nrst |=> (flags == '0 && !alt_vector_select && ext_edge_polarity == 3'b000 && !irq))
    else $error("state not zero in reset");

  AST_REDUCED: assert property (
    !FULL_FAMILY |-> ((flag_r[1] & FLG1_REDUCED) == 16'h0000 && (flag_r[4] & FLG4_REDUCED) == 16'h0000))
    else $error("reduced member flag set");

  AST_SW_CLEAR: assert property (
    (wr_en && ((req.adr & 6'h3c) == OFF_FLAGS_0) && req.sel[0] && !wdat[0] && !hw_set[0][0]) |=> !flag_r[0][0])
    else $error("software write of zero did not clear flag");

  AST_SET_WINS: assert property (
    (wr_en && ((req.adr & 6'h3c) == OFF_FLAGS_0) && req.sel[1] && !wdat[15] && flag_set[0][15]) |=> flag_r[0][15])
    else $error("clear beat simultaneous hardware set");

  AST_CTL_RO: assert property (
    (wr_en && ((req.adr & 6'h3c) == OFF_CTL_TWO)) |=> (ctl_r.dis_act == $past(irq_disable_active)))
    else $error("write disturbed read-only status");

  AST_IRQ: assert property (
    (ev_stat_r & ev_mask_r) != 5'h00 |=> irq)
    else $error("unmasked event did not raise interrupt");

  AST_IRQ_LOW: assert property (
    (ev_stat_r & ev_mask_r) == 5'h00 |=> !irq)
    else $error("interrupt high with no unmasked event");

  AST_EV_SET: assert property (
    (|hw_set[2]) |=> ev_stat_r[2])
    else $error("source request did not set its event status bit");

  AST_ACK_ONE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  COV_WRITE_CTL: cover property (wr_en && ((req.adr & 6'h3c) == OFF_CTL_TWO));
  COV_EXT_FALL:  cover property (ctl_r.pol[1] && ext_edge[1]);
  COV_SET_CLEAR: cover property (wr_en && ((req.adr & 6'h3c) == OFF_FLAGS_1) && (|flag_set[1]));
  COV_IRQ:       cover property ($rose(irq));

endmodule : ifr_regs

/* dv/ifr_periph_model.sv */
`timescale 1ns/1ps
module ifr_periph_model
  import ifr_pkg::*;
(
  input  wire logic                         clk,      // System clock
  input  wire logic [IFR_NUM_EXT-1:0]       pin_lvl,  // Wanted pin levels
  output logic      [IFR_NUM_FLG-1:0][15:0] src_set = '0, // Source set pulses
  output logic      [IFR_NUM_EXT-1:0]       pin_drv = '0  // External pins
);
  // Pins follow the wanted level one edge late, like a slow source
  always @(posedge clk)
    pin_drv <= pin_lvl;

  // One-cycle request from the sources of flag register k
  task automatic pulse(input int k, input logic [15:0] v);
    src_set[k] <= v;
    @(posedge clk);
    src_set[k] <= '0;
  endtask : pulse
endmodule : ifr_periph_model

/* dv/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", nm, e, s); end end
module tb
  import ifr_pkg::*;
;
  logic                         clk  = 1'b0;
  logic                         nrst = 1'b0;
  logic                         dis  = 1'b0;
  logic [2:0]                   pins = '0;
  ifr_wb_req_t                  req  = '0;
  logic [31:0]                  rdat;
  logic [31:0]                  exp_w;
  logic                         ack;
  logic                         alt;
  logic                         irq;
  logic [2:0]                   pol;
  logic [2:0]                   pin_w;
  logic [IFR_NUM_FLG-1:0][15:0] fset;
  logic [IFR_NUM_FLG-1:0][15:0] flg;
  logic [IFR_NUM_FLG-1:0][15:0] flg_red;
  logic [15:0]                  red[5] = '{FLG0_REDUCED, FLG1_REDUCED, FLG2_REDUCED, FLG3_REDUCED, FLG4_REDUCED};
  logic [15:0]                  q[$];
  logic [15:0]                  impl[5] = '{16'hb9cd, 16'hea1f, 16'h0020, 16'h0006, 16'h0106};
  logic [15:0]                  v;
  logic [31:0]                  seed = 32'h3cdcb065;
  int                           error_cnt = 0;
  int                           checked = 0;

  initial
    forever #10 clk = ~clk;

  ifr_periph_model peri (.clk(clk), .pin_lvl(pins), .src_set(fset), .pin_drv(pin_w));

  ifr_regs dut (
    .clk(clk), .nrst(nrst), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
    .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .flag_set(fset), .irq_disable_active(dis), .ext_pin(pin_w),
    .alt_vector_select(alt), .ext_edge_polarity(pol), .flags(flg), .irq(irq)
  );

  // Reduced member on the same bus and sources; only its flags are watched
  ifr_regs #(.FULL_FAMILY(1'b0)) dut_red (
    .clk(clk), .nrst(nrst), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
    .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(),
    .wb_ack_o(), .flag_set(fset), .irq_disable_active(dis), .ext_pin(pin_w),
    .alt_vector_select(), .ext_edge_polarity(), .flags(flg_red), .irq()
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic wb(input logic w, input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h3, adr: a, dat: {16'h0, d}};
    do @(posedge clk); while (ack !== 1'b1);
    req <= '0;
  endtask : wb

  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    q.push_back(e);
    wb(1'b0, a, 16'h0);
  endtask : rd

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  // Read results are matched against the oldest pending expectation
  always @(posedge clk)
    if (ack === 1'b1 && req.we === 1'b0)
    begin
      exp_w = {16'h0, q.pop_front()};
      `CHK("read data", exp_w, rdat)
    end

  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (int k = 0; k < 9; k++)
      rd(6'(4 * k), 16'h0);
    wb(1'b1, 6'h20, 16'hffff);
    rd(6'h20, 16'h0);
    wb(1'b1, OFF_CTL_TWO, 16'hffff);
    rd(OFF_CTL_TWO, 16'h8007);
    `CHK("alt", 1'b1, alt)
    `CHK("polarity", 3'h7, pol)
    dis <= 1'b1;
    wb(1'b1, OFF_CTL_TWO, 16'h0);
    rd(OFF_CTL_TWO, 16'h4000);
    `CHK("alt", 1'b0, alt)
    dis <= 1'b0;
    rd(OFF_CTL_TWO, 16'h0);
    for (int k = 0; k < 5; k++)
    begin
      v = 16'(rnd());
      wb(1'b1, OFF_FLAGS_0 + 6'(4 * k), v);
      rd(OFF_FLAGS_0 + 6'(4 * k), v & impl[k]);
      wb(1'b1, OFF_FLAGS_0 + 6'(4 * k), 16'h0);
      peri.pulse(k, 16'hffff);
      rd(OFF_FLAGS_0 + 6'(4 * k), impl[k]);
      `CHK("flags", impl[k], flg[k])
      `CHK("reduced flags", impl[k] & ~red[k], flg_red[k])
      wb(1'b1, OFF_FLAGS_0 + 6'(4 * k), 16'h0);
      rd(OFF_FLAGS_0 + 6'(4 * k), 16'h0);
    end
    // Source request lands on the very edge of a clearing write
    wb(1'b1, OFF_FLAGS_0, 16'hffff);
    fork
      wb(1'b1, OFF_FLAGS_0, 16'h0);
      begin
        @(posedge clk iff (req.cyc === 1'b1 && ack !== 1'b1));
        peri.pulse(0, 16'h0008);
      end
    join
    rd(OFF_FLAGS_0, 16'h0008);
    wb(1'b1, OFF_EV_STAT, 16'h001f);
    wb(1'b1, OFF_EV_MASK, 16'h0004);
    peri.pulse(2, 16'h0020);
    repeat (2) @(posedge clk);
    #1 `CHK("irq", 1'b1, irq)
    rd(OFF_EV_STAT, 16'h0004);
    wb(1'b1, OFF_EV_MASK, 16'h0);
    repeat (2) @(posedge clk);
    #1 `CHK("irq", 1'b0, irq)
    wb(1'b1, OFF_EV_STAT, 16'h0004);
    rd(OFF_EV_STAT, 16'h0);
    wb(1'b1, OFF_CTL_TWO, 16'h0001);
    wb(1'b1, OFF_FLAGS_0, 16'h0);
    pins <= 3'b001;
    repeat (8) @(posedge clk);
    rd(OFF_FLAGS_0, 16'h0);
    pins <= 3'b000;
    repeat (8) @(posedge clk);
    rd(OFF_FLAGS_0, 16'h0001);
    pins <= 3'b010;
    repeat (8) @(posedge clk);
    pins <= 3'b110;
    repeat (8) @(posedge clk);
    rd(OFF_FLAGS_1, 16'h2010);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    rd(OFF_FLAGS_1, 16'h0);
    @(posedge clk);
    `CHK("pending", 0, q.size())
    finish_test();
  end
endmodule : tb
